/* rtl/ebs_pin_mux.sv */
// Bus selection register, pin routing and clock source select
//
// Functional notes
// - Strap low: oscillator clocks RTC and generator
// - Strap high: external clock feeds generator
// - Register decoded at I/O address 0x1c00
// - Register routes functions onto parallel port
// - Register selects serial port pin functions
// - New routing applies on next clock
// - Per-pin bit: 1 GPIO, 0 EMIF address
// - Bit 15 reserved, read-only, ignores writes
// - Bits 14:12 select parallel port mode
// - Bits 11:10 select serial port 1 mode
// - Bits 9:8 select serial port 0 mode
`timescale 1ns/1ps
`default_nettype none
`include "ebs_map.svh"
module ebs_pin_mux #(
    parameter int EMIF_PINS = 6
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // I/O port space access
    input  wire logic [15:0]          io_addr,
    input  wire logic                 io_wr,
    input  wire logic                 io_rd,
    input  wire logic [15:0]          io_wdata,
    output logic      [15:0]          io_rdata,
    output logic                      io_sel,
    // Clock select strap and clock sources
    input  wire logic                 clk_sel_strap,
    input  wire logic                 osc32k_clk,
    input  wire logic                 external_clock_pin,
    output logic                      rtc_clk_src,
    output logic                      clkgen_clk_src,
    output logic                      clk_sel_q,
    // Routing selections
    output logic [2:0]                parallel_port_mode,
    output logic [1:0]                serial_port1_mode,
    output logic [1:0]                serial_port0_mode,
    output logic [EMIF_PINS-1:0]      emif_address_pins_gpio,
    // Decoded routing enables
    output logic                      pp_spi_en,
    output logic                      pp_spi_full,
    output logic                      pp_uart_en,
    output logic                      pp_i2s2_en,
    output logic                      pp_i2s3_en,
    output logic                      pp_gpio_en,
    output logic                      sp1_i2s_en,
    output logic                      sp1_gpio_all,
    output logic                      sp0_mmc_en,
    output logic                      sp0_i2s_en,
    output logic                      sp0_gpio_all
);

    ////////////////////////////////////////////////////////////////////////
    // Strap capture
    logic       strap_s1_q;
    logic       strap_s2_q;
    logic       strap_done_q;
    logic       strap_done_d;
    logic       clk_sel_d;
    logic [1:0] strap_cnt_q;
    logic [1:0] strap_cnt_d;
    logic       strap_take;

    always_comb begin
        // Wait until the synchroniser holds the pin, not its reset zero
        strap_take   = !strap_done_q && (strap_cnt_q == `EBS_STRAP_CAP_CNT);
        strap_cnt_d  = strap_done_q ? strap_cnt_q : strap_cnt_q + 2'h1;
        strap_done_d = strap_done_q | strap_take;
        // Captured once after reset; a moving strap is ignored until reset
        clk_sel_d = strap_take ? strap_s2_q : clk_sel_q;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strap_s1_q   <= 1'b0;
            strap_s2_q   <= 1'b0;
            strap_done_q <= 1'b0;
            strap_cnt_q  <= 2'h0;
            clk_sel_q    <= 1'b0;
        end else begin
            strap_s1_q   <= clk_sel_strap;
            strap_s2_q   <= strap_s1_q;
            strap_done_q <= strap_done_d;
            strap_cnt_q  <= strap_cnt_d;
            clk_sel_q    <= clk_sel_d;
        end
    end

    // Pure clock steering; glitch-free switching is not needed as the
    // strap is static during operation
    assign rtc_clk_src    = osc32k_clk;
    assign clkgen_clk_src = clk_sel_q ? external_clock_pin
                                      : osc32k_clk;

    ////////////////////////////////////////////////////////////////////////
    // Bus selection register
    logic [15:0] sel_q;
    logic [15:0] sel_d;
    logic        hit;

    assign hit    = (io_addr == `EBS_SEL_ADDR);
    assign io_sel = hit & (io_wr | io_rd);

    always_comb begin
        sel_d = sel_q;
        if (hit && io_wr) begin
            // Reserved bits never store
            sel_d = io_wdata & `EBS_WR_MASK;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_q <= `EBS_SEL_RESET;
        end else begin
            sel_q <= sel_d;
        end
    end

    always_comb begin
        io_rdata = 16'h0000;
        if (hit && io_rd) begin
            io_rdata = sel_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field extraction and routing
    ebs_cfg_if cfg ();

    assign parallel_port_mode =
        sel_q[`EBS_PP_MSB:`EBS_PP_LSB];
    assign serial_port1_mode  =
        sel_q[`EBS_SP1_MSB:`EBS_SP1_LSB];
    assign serial_port0_mode  =
        sel_q[`EBS_SP0_MSB:`EBS_SP0_LSB];

    genvar gi;
    generate
        for (gi = 0; gi < EMIF_PINS; gi++) begin : g_emif
            assign emif_address_pins_gpio[gi] =
                cfg.emif_gpio_sel[gi];
        end
    endgenerate

    assign cfg.parallel_port_mode =
        ebs_pkg::ebs_pp_mode_t'(parallel_port_mode);
    assign cfg.serial_port1_mode  =
        ebs_pkg::ebs_sp_mode_t'(serial_port1_mode);
    assign cfg.serial_port0_mode  =
        ebs_pkg::ebs_sp_mode_t'(serial_port0_mode);
    assign cfg.emif_gpio_sel      = sel_q[`EBS_A_MSB:`EBS_A_LSB];

    ebs_route u_route (
        .cfg          (cfg),
        .pp_spi_en    (pp_spi_en),
        .pp_spi_full  (pp_spi_full),
        .pp_uart_en   (pp_uart_en),
        .pp_i2s2_en   (pp_i2s2_en),
        .pp_i2s3_en   (pp_i2s3_en),
        .pp_gpio_en   (pp_gpio_en),
        .sp1_i2s_en   (sp1_i2s_en),
        .sp1_gpio_all (sp1_gpio_all),
        .sp0_mmc_en   (sp0_mmc_en),
        .sp0_i2s_en   (sp0_i2s_en),
        .sp0_gpio_all (sp0_gpio_all)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_sel_write;
        hit && io_wr;
    endsequence

    a_write_stores: assert property (@(posedge clk) disable iff (!nrst)
        s_sel_write |=> sel_q == ($past(io_wdata) & `EBS_WR_MASK))
        else $error("register did not take write");
    a_rsvd_zero: assert property (@(posedge clk) disable iff (!nrst)
        sel_q[15] == 1'b0 && sel_q[7:6] == 2'b00)
        else $error("reserved bit set");
    a_hold_value: assert property (@(posedge clk) disable iff (!nrst)
        !(hit && io_wr) |=> $stable(sel_q))
        else $error("register changed without write");
    a_read_back: assert property (@(posedge clk) disable iff (!nrst)
        hit && io_rd |-> io_rdata == sel_q)
        else $error("readback mismatch");
    a_pp_route: assert property (@(posedge clk) disable iff (!nrst)
        s_sel_write ##1 (parallel_port_mode == 3'h2) |-> pp_gpio_en && !pp_spi_en)
        else $error("parallel port mode 2 wrong");
    a_sp0_route: assert property (@(posedge clk) disable iff (!nrst)
        serial_port0_mode == 2'h0 |-> sp0_mmc_en && !sp0_i2s_en)
        else $error("serial port 0 mode 0 wrong");
    a_sp1_route: assert property (@(posedge clk) disable iff (!nrst)
        serial_port1_mode == 2'h1 |-> sp1_i2s_en && !sp1_gpio_all)
        else $error("serial port 1 mode 1 wrong");
    a_emif_bit: assert property (@(posedge clk) disable iff (!nrst)
        s_sel_write |=> emif_address_pins_gpio == $past(io_wdata[5:0]))
        else $error("emif pin select wrong");
    a_strap_held: assert property (@(posedge clk) disable iff (!nrst)
        strap_done_q ##1 strap_done_q |-> $stable(clk_sel_q))
        else $error("clock select changed after capture");
    a_strap_take: assert property (@(posedge clk) disable iff (!nrst)
        strap_take |=> clk_sel_q == $past(strap_s2_q))
        else $error("clock select did not capture strap");

endmodule
`default_nettype wire

/* rtl/ebs_map.svh */
// Register map, field positions and reset values of the bus selection block
`ifndef EBS_MAP_SVH
`define EBS_MAP_SVH

`define EBS_SEL_ADDR      16'h1c00
`define EBS_RSVD15_BIT    15
`define EBS_PP_MSB        14
`define EBS_PP_LSB        12
`define EBS_SP1_MSB       11
`define EBS_SP1_LSB       10
`define EBS_SP0_MSB       9
`define EBS_SP0_LSB       8
`define EBS_A_MSB         5
`define EBS_A_LSB         0
`define EBS_WR_MASK       16'h7f3f
`define EBS_SEL_RESET     16'h0000
`define EBS_STRAP_CAP_CNT 2'h2

`endif

/* rtl/ebs_pkg.sv */
// Types shared by the bus selection block
package ebs_pkg;

    typedef enum logic [2:0] {
        EBS_PP_MODE0 = 3'b000,
        EBS_PP_MODE1 = 3'b001,
        EBS_PP_MODE2 = 3'b010,
        EBS_PP_MODE3 = 3'b011,
        EBS_PP_MODE4 = 3'b100,
        EBS_PP_MODE5 = 3'b101,
        EBS_PP_MODE6 = 3'b110,
        EBS_PP_RSVD  = 3'b111
    } ebs_pp_mode_t;

    typedef enum logic [1:0] {
        EBS_SP_MODE0 = 2'b00,
        EBS_SP_MODE1 = 2'b01,
        EBS_SP_MODE2 = 2'b10,
        EBS_SP_RSVD  = 2'b11
    } ebs_sp_mode_t;

endpackage

/* rtl/ebs_cfg_if.sv */
// Decoded routing selections passed from the register to the pin decoder
`timescale 1ns/1ps
`default_nettype none
interface ebs_cfg_if;
    ebs_pkg::ebs_pp_mode_t parallel_port_mode;
    ebs_pkg::ebs_sp_mode_t serial_port1_mode;
    ebs_pkg::ebs_sp_mode_t serial_port0_mode;
    logic [5:0]            emif_gpio_sel;

    modport src (output parallel_port_mode, serial_port1_mode,
                 serial_port0_mode, emif_gpio_sel);
    modport dst (input parallel_port_mode, serial_port1_mode,
                 serial_port0_mode, emif_gpio_sel);
endinterface
`default_nettype wire

/* rtl/ebs_route.sv */
// Mode-to-route decoder for the parallel and serial ports
`timescale 1ns/1ps
`default_nettype none
module ebs_route (
    // Selections
    ebs_cfg_if.dst     cfg,
    // Per-function routing enables
    output logic       pp_spi_en,
    output logic       pp_spi_full,
    output logic       pp_uart_en,
    output logic       pp_i2s2_en,
    output logic       pp_i2s3_en,
    output logic       pp_gpio_en,
    output logic       sp1_i2s_en,
    output logic       sp1_gpio_all,
    output logic       sp0_mmc_en,
    output logic       sp0_i2s_en,
    output logic       sp0_gpio_all
);
    always_comb begin
        pp_spi_en   = 1'b0;
        pp_spi_full = 1'b0;
        pp_uart_en  = 1'b0;
        pp_i2s2_en  = 1'b0;
        pp_i2s3_en  = 1'b0;
        pp_gpio_en  = 1'b0;
        unique case (cfg.parallel_port_mode)
            ebs_pkg::EBS_PP_MODE1: begin
                pp_spi_en   = 1'b1;
                pp_spi_full = 1'b1;
                pp_gpio_en  = 1'b1;
                pp_uart_en  = 1'b1;
                pp_i2s2_en  = 1'b1;
            end
            ebs_pkg::EBS_PP_MODE2: pp_gpio_en = 1'b1;
            ebs_pkg::EBS_PP_MODE3: begin
                pp_spi_en  = 1'b1;
                pp_i2s3_en = 1'b1;
            end
            ebs_pkg::EBS_PP_MODE4: begin
                pp_i2s2_en = 1'b1;
                pp_uart_en = 1'b1;
            end
            ebs_pkg::EBS_PP_MODE5: begin
                pp_spi_en  = 1'b1;
                pp_uart_en = 1'b1;
            end
            ebs_pkg::EBS_PP_MODE6: begin
                pp_spi_en   = 1'b1;
                pp_spi_full = 1'b1;
                pp_i2s2_en  = 1'b1;
                pp_i2s3_en  = 1'b1;
                pp_gpio_en  = 1'b1;
            end
            // Mode 0 and the unused code leave the port idle
            default: pp_gpio_en = 1'b0;
        endcase
    end

    always_comb begin
        sp1_i2s_en   = (cfg.serial_port1_mode == ebs_pkg::EBS_SP_MODE1);
        sp1_gpio_all = (cfg.serial_port1_mode == ebs_pkg::EBS_SP_MODE2);
        sp0_mmc_en   = (cfg.serial_port0_mode == ebs_pkg::EBS_SP_MODE0);
        sp0_i2s_en   = (cfg.serial_port0_mode == ebs_pkg::EBS_SP_MODE1);
        sp0_gpio_all = (cfg.serial_port0_mode == ebs_pkg::EBS_SP_MODE2);
    end
endmodule
`default_nettype wire

/* verification/ebs_src_model.sv */
// Clock source and strap pin model on the far side of the block
`timescale 1ns/1ps
`default_nettype none
module ebs_src_model (
    // Strap level requested by the bench
    input  wire logic strap_tgt,
    // Pins seen by the device
    output logic      osc32k_clk,
    output logic      external_clock_pin,
    output logic      clk_sel_strap
);
    // Static board strap; only changed around a device reset
    assign clk_sel_strap = strap_tgt;

    // Edges kept off both CPU clock edges so sampling never races
    initial begin
        osc32k_clk = 1'b0;
        #2;
        forever #20 osc32k_clk = ~osc32k_clk;
    end

    initial begin
        external_clock_pin = 1'b1;
        #7;
        forever #15 external_clock_pin = ~external_clock_pin;
    end
endmodule
`default_nettype wire

/* verification/tb_ebs_pin_mux.sv */
// Self-checking bench for the bus selection block
`timescale 1ns/1ps
`default_nettype none
`include "ebs_map.svh"
module tb_ebs_pin_mux;
    logic        clk, nrst, io_wr, io_rd, io_sel;
    logic        strap_tgt, strap_exp, clk_chk;
    logic        osc32k_clk, external_clock_pin, clk_sel_strap;
    logic        rtc_clk_src, clkgen_clk_src, clk_sel_q;
    logic [15:0] io_addr, io_wdata, io_rdata, reg_m, rnd;
    logic [2:0]  pp_mode, sp0_en;
    logic [1:0]  sp1_mode, sp0_mode, sp1_en;
    logic [5:0]  emif_gpio, pp_en;
    logic [40:0] exp_q[$];
    int          mismatches, checks_done;

    ebs_pin_mux #(.EMIF_PINS(6)) u_ebs_pin_mux (
        .clk(clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_sel(io_sel), .clk_sel_strap(clk_sel_strap),
        .osc32k_clk(osc32k_clk), .external_clock_pin(external_clock_pin),
        .rtc_clk_src(rtc_clk_src), .clkgen_clk_src(clkgen_clk_src),
        .clk_sel_q(clk_sel_q), .parallel_port_mode(pp_mode),
        .serial_port1_mode(sp1_mode), .serial_port0_mode(sp0_mode),
        .emif_address_pins_gpio(emif_gpio),
        .pp_spi_en(pp_en[5]), .pp_spi_full(pp_en[4]),
        .pp_uart_en(pp_en[3]), .pp_i2s2_en(pp_en[2]),
        .pp_i2s3_en(pp_en[1]), .pp_gpio_en(pp_en[0]),
        .sp1_i2s_en(sp1_en[1]), .sp1_gpio_all(sp1_en[0]),
        .sp0_mmc_en(sp0_en[2]), .sp0_i2s_en(sp0_en[1]),
        .sp0_gpio_all(sp0_en[0])
    );

    ebs_src_model u_ebs_src_model (
        .strap_tgt(strap_tgt), .osc32k_clk(osc32k_clk),
        .external_clock_pin(external_clock_pin),
        .clk_sel_strap(clk_sel_strap)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [40:0] expect_obs(input logic hit,
                                               input logic [15:0] r);
        logic [5:0] pp;
        logic [1:0] s1;
        logic [2:0] s0;
        case (r[14:12])
            3'h1: pp = 6'h3d;
            3'h2: pp = 6'h01;
            3'h3: pp = 6'h22;
            3'h4: pp = 6'h0c;
            3'h5: pp = 6'h28;
            3'h6: pp = 6'h37;
            default: pp = 6'h00;
        endcase
        s1 = (r[11:10] == 2'h1) ? 2'h2 : (r[11:10] == 2'h2) ? 2'h1 : 2'h0;
        s0 = (r[9:8] == 2'h0) ? 3'h4 : (r[9:8] == 2'h1) ? 3'h2 :
             (r[9:8] == 2'h2) ? 3'h1 : 3'h0;
        return {hit, hit ? r : 16'h0000, r[14:8], r[5:0], pp, s1, s0};
    endfunction

    task automatic check(input logic [40:0] seen, input logic [40:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic test_done();
        if (mismatches == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Callers sit on a falling edge; a write is always followed by a read
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
        if (a == `EBS_SEL_ADDR)
            reg_m = d & `EBS_WR_MASK;
    endtask

    task automatic rd(input logic [15:0] a);
        io_addr = a;
        io_rd = 1'b1;
        exp_q.push_back(expect_obs(a == `EBS_SEL_ADDR, reg_m));
        @(negedge clk);
        io_rd = 1'b0;
        @(negedge clk);
    endtask

    task automatic do_reset(input logic s);
        clk_chk = 1'b0;
        nrst = 1'b0;
        reg_m = 16'h0000;
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        strap_exp = s;
        clk_chk = 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        #1;
        if (nrst && io_rd) begin
            if (exp_q.size() == 0)
                check(41'h0, ~41'h0);
            else
                check({io_sel, io_rdata, pp_mode, sp1_mode, sp0_mode, emif_gpio, pp_en, sp1_en, sp0_en}, exp_q.pop_front());
        end
        if (nrst && clk_chk)
            check({38'h0, clk_sel_q, rtc_clk_src, clkgen_clk_src}, {38'h0, strap_exp, osc32k_clk, strap_exp ? external_clock_pin : osc32k_clk});
    end

    initial begin
        #100us;
        mismatches++;
        test_done();
    end

    initial begin
        {nrst, io_wr, io_rd, strap_tgt, strap_exp, clk_chk} = 6'h00;
        {io_addr, io_wdata, reg_m} = 48'h0;
        mismatches = 0;
        checks_done = 0;
        rnd = 16'($urandom(98));
        do_reset(1'b0);
        rd(`EBS_SEL_ADDR);
        // Every mode code, reserved bits forced high
        for (int i = 0; i < 8; i++) begin
            do_reset(1'b0);
            wr(`EBS_SEL_ADDR, {1'b1, 3'(i), 2'(i), 2'(7 - i), 2'h3,
                               6'(1 << (i % 6))});
            rd(`EBS_SEL_ADDR);
        end
        wr(16'h1c01, 16'hffff);
        rd(16'h1c01);
        rd(16'h0c00);
        rd(`EBS_SEL_ADDR);
        repeat (40) begin
            rnd = 16'($urandom);
            do_reset(1'b0);
            wr(`EBS_SEL_ADDR, rnd);
            rd(`EBS_SEL_ADDR);
        end
        // Strap moved without a reset must be ignored
        strap_tgt = 1'b1;
        repeat (20) @(negedge clk);
        do_reset(1'b1);
        rd(`EBS_SEL_ADDR);
        repeat (20) @(negedge clk);
        test_done();
    end
endmodule
`default_nettype wire
